// *** rtl/fcs_flash_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_ctrl (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Flash pins
  output logic [18:0] FL_ADDR,
  output logic [15:0] FL_DQ_OUT,
  output logic FL_DQ_OE,
  input wire logic [15:0] FL_DQ_IN,
  output logic FL_CE_N,
  output logic FL_WE_N,
  output logic FL_OE_N,
  input wire logic FL_READY_BUSY_N
);
  fcs_cyc_if cyc ();

  fcs_pkg::fcs_seq_state_t state_reg;
  logic [3:0] op_reg;
  logic [18:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [2:0] step_reg;
  logic [1:0] phase_reg;
  logic prev_tgl_reg;
  logic [15:0] last_rd_reg;
  logic done_reg;
  logic fail_reg;
  logic rb_s1_reg;
  logic rb_s2_reg;
  logic [31:0] rd_data_reg;

  function automatic fcs_pkg::fcs_step_t seq_step(input logic [3:0] op,
                                                  input logic [2:0] i);
    fcs_pkg::fcs_step_t s;
    s = '{rd: 1'b0, pd: 1'b0, asel: fcs_pkg::ASEL_CONST,
          a: 12'h000, d: 8'h00};
    case (op)
      fcs_pkg::OP_READ: begin
        s.rd = 1'b1;
        s.asel = fcs_pkg::ASEL_USER;
      end
      fcs_pkg::OP_SUSPEND: s.d = fcs_pkg::CODE_SUSPEND;
      fcs_pkg::OP_RESUME: s.d = fcs_pkg::CODE_RESUME;
      fcs_pkg::OP_RESET: s.d = fcs_pkg::CODE_RESET;
      fcs_pkg::OP_BYP_PROG: begin
        if (i == 3'h0) begin
          s.d = fcs_pkg::CODE_PROG;
        end else begin
          s.pd = 1'b1;
          s.asel = fcs_pkg::ASEL_USER;
        end
      end
      fcs_pkg::OP_BYP_RESET: begin
        s.d = (i == 3'h0) ? fcs_pkg::CODE_BYP_EXIT1 : fcs_pkg::CODE_BYP_EXIT2;
      end
      default: begin
        case (i)
          3'h0, 3'h3: begin
            s.a = fcs_pkg::UNLOCK_ADDR1;
            s.d = fcs_pkg::UNLOCK_DATA1;
          end
          3'h1, 3'h4: begin
            s.a = fcs_pkg::UNLOCK_ADDR2;
            s.d = fcs_pkg::UNLOCK_DATA2;
          end
          3'h2: begin
            s.a = fcs_pkg::UNLOCK_ADDR1;
            case (op)
              fcs_pkg::OP_PROG: s.d = fcs_pkg::CODE_PROG;
              fcs_pkg::OP_BYP_ENTER: s.d = fcs_pkg::CODE_BYP_ENTER;
              fcs_pkg::OP_ID_READ, fcs_pkg::OP_PROT_VERIFY: begin
                s.d = fcs_pkg::CODE_AUTOSEL;
              end
              default: s.d = fcs_pkg::CODE_ERASE_SETUP;
            endcase
          end
          3'h5: begin
            if (op == fcs_pkg::OP_CHIP_ERASE) begin
              s.a = fcs_pkg::UNLOCK_ADDR1;
              s.d = fcs_pkg::CODE_CHIP_ERASE;
            end else begin
              s.asel = fcs_pkg::ASEL_USER;
              s.d = fcs_pkg::CODE_SECT_ERASE;
            end
          end
          default: begin
            s.asel = fcs_pkg::ASEL_USER;
            s.d = fcs_pkg::CODE_RESET;
          end
        endcase
        // Fourth cycle differs per family: data, erase unlock, or code read
        if (i == 3'h3) begin
          case (op)
            fcs_pkg::OP_PROG: begin
              s.pd = 1'b1;
              s.asel = fcs_pkg::ASEL_USER;
            end
            fcs_pkg::OP_ID_READ: begin
              s.rd = 1'b1;
              s.asel = fcs_pkg::ASEL_USER;
            end
            fcs_pkg::OP_PROT_VERIFY: begin
              s.rd = 1'b1;
              s.asel = fcs_pkg::ASEL_SECT;
            end
            default: s.rd = 1'b0;
          endcase
        end
        // Autoselect is left with a reset write
        if (i == 3'h4 && (op == fcs_pkg::OP_ID_READ ||
                          op == fcs_pkg::OP_PROT_VERIFY)) begin
          s.asel = fcs_pkg::ASEL_CONST;
          s.a = 12'h000;
          s.d = fcs_pkg::CODE_RESET;
        end
      end
    endcase
    return s;
  endfunction

  function automatic logic [2:0] seq_len(input logic [3:0] op);
    case (op)
      fcs_pkg::OP_BYP_PROG, fcs_pkg::OP_BYP_RESET: return 3'h2;
      fcs_pkg::OP_BYP_ENTER: return 3'h3;
      fcs_pkg::OP_PROG: return 3'h4;
      fcs_pkg::OP_ID_READ, fcs_pkg::OP_PROT_VERIFY: return 3'h5;
      fcs_pkg::OP_SECT_ERASE, fcs_pkg::OP_CHIP_ERASE: return 3'h6;
      default: return 3'h1;
    endcase
  endfunction

  fcs_pkg::fcs_step_t cur_step;
  wire logic [2:0] cur_len;
  wire logic last_step;
  wire logic needs_poll;
  wire logic [18:0] step_addr;
  wire logic [15:0] step_data;
  wire logic idle;
  wire logic ctrl_wr;
  wire logic status_wr;
  wire logic tgl_now;
  wire logic tgl_same;
  wire logic limit_hit;
  wire logic finish_ok;
  wire logic finish_fail;
  wire logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign cur_step = seq_step(op_reg, step_reg);
  assign cur_len = seq_len(op_reg);
  assign last_step = (step_reg == cur_len - 3'h1);
  // Only operations that start an embedded algorithm are polled
  assign needs_poll = (op_reg == fcs_pkg::OP_PROG) ||
                      (op_reg == fcs_pkg::OP_BYP_PROG) ||
                      (op_reg == fcs_pkg::OP_SECT_ERASE) ||
                      (op_reg == fcs_pkg::OP_CHIP_ERASE);
  // Command cycles zero the don't-care address and data bits
  assign step_addr = (cur_step.asel == fcs_pkg::ASEL_USER) ? addr_reg :
                     (cur_step.asel == fcs_pkg::ASEL_SECT) ?
                     {addr_reg[18:12], fcs_pkg::PROT_VERIFY_LOW} :
                     {7'h00, cur_step.a};
  assign step_data = cur_step.pd ? wdata_reg : {8'h00, cur_step.d};
  assign idle = (state_reg == fcs_pkg::S_IDLE);
  assign ctrl_wr = REG_WR && (REG_ADDR == fcs_pkg::OFF_CTRL);
  assign status_wr = REG_WR && (REG_ADDR == fcs_pkg::OFF_STATUS);

  assign cyc.req = cyc.rdy && (state_reg == fcs_pkg::S_STEP ||
                               state_reg == fcs_pkg::S_POLL ||
                               state_reg == fcs_pkg::S_ABORT);
  assign cyc.is_read = (state_reg == fcs_pkg::S_POLL) ||
                       (state_reg == fcs_pkg::S_STEP && cur_step.rd);
  assign cyc.addr = (state_reg == fcs_pkg::S_STEP) ? step_addr :
                    (state_reg == fcs_pkg::S_ABORT) ? 19'h00000 : addr_reg;
  assign cyc.wdata = (state_reg == fcs_pkg::S_ABORT) ?
                     {8'h00, fcs_pkg::CODE_RESET} : step_data;

  // Toggle algorithm on each completed status read
  assign tgl_now = cyc.rdata[fcs_pkg::TOGGLE_STATUS_BIT_ONE];
  assign tgl_same = (tgl_now == prev_tgl_reg);
  assign limit_hit = cyc.rdata[fcs_pkg::TIMING_LIMIT_FAIL_BIT];
  assign finish_ok = (state_reg == fcs_pkg::S_POLL_WAIT) && cyc.done &&
                     (phase_reg != 2'h0) && tgl_same;
  assign finish_fail = (state_reg == fcs_pkg::S_POLL_WAIT) && cyc.done &&
                       (phase_reg == 2'h2) && !tgl_same;

  assign status_word = {28'h0000000, rb_s2_reg, fail_reg, done_reg, ~idle};
  always_comb begin
    case (REG_ADDR)
      fcs_pkg::OFF_CTRL: rd_mux = {28'h0000000, op_reg};
      fcs_pkg::OFF_ADDR: rd_mux = {13'h0000, addr_reg};
      fcs_pkg::OFF_WDATA: rd_mux = {16'h0000, wdata_reg};
      fcs_pkg::OFF_STATUS: rd_mux = status_word;
      fcs_pkg::OFF_RDATA: rd_mux = {16'h0000, last_rd_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
      rd_data_reg <= 32'h00000000;
      addr_reg <= 19'h00000;
      wdata_reg <= 16'h0000;
    end else if (CLK_EN) begin
      rb_s1_reg <= FL_READY_BUSY_N;
      rb_s2_reg <= rb_s1_reg;
      rd_data_reg <= REG_RD ? rd_mux : 32'h00000000;
      if (REG_WR && idle && REG_ADDR == fcs_pkg::OFF_ADDR) begin
        addr_reg <= REG_WDATA[18:0];
      end
      if (REG_WR && idle && REG_ADDR == fcs_pkg::OFF_WDATA) begin
        wdata_reg <= REG_WDATA[15:0];
      end
    end
  end

  // Sticky flags: a set in the same cycle beats the software clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else if (CLK_EN) begin
      if (status_wr && REG_WDATA[fcs_pkg::ST_DONE]) begin
        done_reg <= 1'b0;
      end
      if (status_wr && REG_WDATA[fcs_pkg::ST_FAIL]) begin
        fail_reg <= 1'b0;
      end
      if (finish_ok || (state_reg == fcs_pkg::S_STEP_WAIT && cyc.done &&
                        last_step && !needs_poll) ||
          (state_reg == fcs_pkg::S_ABORT && cyc.done)) begin
        done_reg <= 1'b1;
      end
      if (finish_fail) begin
        fail_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= fcs_pkg::S_IDLE;
      op_reg <= fcs_pkg::OP_READ;
      step_reg <= 3'h0;
      phase_reg <= 2'h0;
      prev_tgl_reg <= 1'b0;
      last_rd_reg <= 16'h0000;
    end else if (CLK_EN) begin
      case (state_reg)
        fcs_pkg::S_IDLE: begin
          if (ctrl_wr && REG_WDATA[3:0] <= fcs_pkg::OP_LAST) begin
            op_reg <= REG_WDATA[3:0];
            step_reg <= 3'h0;
            phase_reg <= 2'h0;
            state_reg <= fcs_pkg::S_STEP;
          end
        end
        fcs_pkg::S_STEP: begin
          if (cyc.req) begin
            state_reg <= fcs_pkg::S_STEP_WAIT;
          end
        end
        fcs_pkg::S_STEP_WAIT: begin
          if (cyc.done) begin
            if (cur_step.rd) begin
              last_rd_reg <= cyc.rdata;
            end
            if (!last_step) begin
              step_reg <= step_reg + 3'h1;
              state_reg <= fcs_pkg::S_STEP;
            end else if (needs_poll) begin
              // Status is valid once the final write strobe has risen
              state_reg <= fcs_pkg::S_POLL;
            end else begin
              state_reg <= fcs_pkg::S_IDLE;
            end
          end
        end
        fcs_pkg::S_POLL: begin
          if (cyc.req) begin
            state_reg <= fcs_pkg::S_POLL_WAIT;
          end
        end
        fcs_pkg::S_POLL_WAIT: begin
          if (cyc.done) begin
            last_rd_reg <= cyc.rdata;
            prev_tgl_reg <= tgl_now;
            state_reg <= fcs_pkg::S_POLL;
            if (phase_reg == 2'h0) begin
              phase_reg <= 2'h1;
            end else if (tgl_same) begin
              state_reg <= fcs_pkg::S_IDLE;
            end else if (phase_reg == 2'h2) begin
              // Still toggling after the limit flag: recover the device
              state_reg <= fcs_pkg::S_ABORT;
            end else if (limit_hit) begin
              phase_reg <= 2'h2;
            end
          end
        end
        fcs_pkg::S_ABORT: begin
          // Idle only once the reset write has left the pins
          if (cyc.done) begin
            state_reg <= fcs_pkg::S_IDLE;
          end
        end
        default: begin
          state_reg <= fcs_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign REG_RDATA = rd_data_reg;

  fcs_bus_cycle u_cycle (
    .clk(CLK),
    .rst(RST),
    .clk_en(CLK_EN),
    .cyc(cyc.eng),
    .fl_addr(FL_ADDR),
    .fl_dq_out(FL_DQ_OUT),
    .fl_dq_oe(FL_DQ_OE),
    .fl_dq_in(FL_DQ_IN),
    .fl_ce_n(FL_CE_N),
    .fl_we_n(FL_WE_N),
    .fl_oe_n(FL_OE_N)
  );
endmodule
`default_nettype wire

// *** rtl/fcs_pkg.sv ***
package fcs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_READY_PIN = 3;

  // Flash status bit positions on the data bus
  localparam int POLL_STATUS_BIT = 7;
  localparam int TOGGLE_STATUS_BIT_ONE = 6;
  localparam int TIMING_LIMIT_FAIL_BIT = 5;
  localparam int ERASE_WINDOW_BIT = 3;
  localparam int TOGGLE_STATUS_BIT_TWO = 2;

  // Operation codes written to the control register
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_PROG = 4'h1;
  localparam logic [3:0] OP_SECT_ERASE = 4'h2;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h3;
  localparam logic [3:0] OP_SUSPEND = 4'h4;
  localparam logic [3:0] OP_RESUME = 4'h5;
  localparam logic [3:0] OP_RESET = 4'h6;
  localparam logic [3:0] OP_ID_READ = 4'h7;
  localparam logic [3:0] OP_PROT_VERIFY = 4'h8;
  localparam logic [3:0] OP_BYP_ENTER = 4'h9;
  localparam logic [3:0] OP_BYP_PROG = 4'ha;
  localparam logic [3:0] OP_BYP_RESET = 4'hb;
  localparam logic [3:0] OP_LAST = 4'hb;

  // Word-mode unlock addresses and command codes
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CODE_PROG = 8'ha0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECT_ERASE = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_RESET = 8'hf0;
  localparam logic [7:0] CODE_AUTOSEL = 8'h90;
  localparam logic [7:0] CODE_BYP_ENTER = 8'h20;
  localparam logic [7:0] CODE_BYP_EXIT1 = 8'h90;
  localparam logic [7:0] CODE_BYP_EXIT2 = 8'h00;
  localparam logic [11:0] PROT_VERIFY_LOW = 12'h002;

  // Bus timing
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int T_REC_NS = 20;
  localparam int SYNC_CYC = 2;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ASEL_CONST = 2'h0,
    ASEL_USER = 2'h1,
    ASEL_SECT = 2'h2
  } fcs_asel_t;

  typedef struct packed {
    logic rd;
    logic pd;
    fcs_asel_t asel;
    logic [11:0] a;
    logic [7:0] d;
  } fcs_step_t;

  typedef enum logic [4:0] {
    E_IDLE = 5'b00001,
    E_SETUP = 5'b00010,
    E_STROBE = 5'b00100,
    E_HOLD = 5'b01000,
    E_GAP = 5'b10000
  } fcs_eng_state_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_STEP = 6'b000010,
    S_STEP_WAIT = 6'b000100,
    S_POLL = 6'b001000,
    S_POLL_WAIT = 6'b010000,
    S_ABORT = 6'b100000
  } fcs_seq_state_t;

endpackage

// *** rtl/fcs_cyc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fcs_cyc_if;
  logic req;
  logic is_read;
  logic [18:0] addr;
  logic [15:0] wdata;
  logic rdy;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, is_read, addr, wdata, input rdy, done, rdata);
  modport eng (input req, is_read, addr, wdata, output rdy, done, rdata);
endinterface
`default_nettype wire

// *** rtl/fcs_bus_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcs_bus_cycle (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Cycle requests
  fcs_cyc_if.eng cyc,
  // Flash pins
  output logic [18:0] fl_addr,
  output logic [15:0] fl_dq_out,
  output logic fl_dq_oe,
  input wire logic [15:0] fl_dq_in,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  fcs_pkg::fcs_eng_state_t state_reg;
  logic [3:0] cnt_reg;
  logic is_rd_reg;
  logic done_reg;
  logic [15:0] rdata_reg;
  logic [15:0] dq_s1_reg;
  logic [15:0] dq_s2_reg;

  assign cyc.rdy = (state_reg == fcs_pkg::E_IDLE);
  assign cyc.done = done_reg;
  assign cyc.rdata = rdata_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= fcs_pkg::E_IDLE;
      cnt_reg <= 4'h0;
      is_rd_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
      fl_addr <= 19'h00000;
      fl_dq_out <= 16'h0000;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
    end else if (clk_en) begin
      dq_s1_reg <= fl_dq_in;
      dq_s2_reg <= dq_s1_reg;
      done_reg <= 1'b0;
      case (state_reg)
        fcs_pkg::E_IDLE: begin
          if (cyc.req) begin
            // Address and data settle before any strobe falls
            fl_addr <= cyc.addr;
            fl_dq_out <= cyc.wdata;
            fl_dq_oe <= ~cyc.is_read;
            is_rd_reg <= cyc.is_read;
            fl_ce_n <= 1'b0;
            state_reg <= fcs_pkg::E_SETUP;
          end
        end
        fcs_pkg::E_SETUP: begin
          state_reg <= fcs_pkg::E_STROBE;
          if (is_rd_reg) begin
            fl_oe_n <= 1'b0;
            // Extra cycles cover the input synchroniser delay
            cnt_reg <= 4'(fcs_pkg::ACC_CYC + fcs_pkg::SYNC_CYC - 1);
          end else begin
            fl_we_n <= 1'b0;
            cnt_reg <= 4'(fcs_pkg::WP_CYC - 1);
          end
        end
        fcs_pkg::E_STROBE: begin
          if (cnt_reg == 4'h0) begin
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            if (is_rd_reg) begin
              rdata_reg <= dq_s2_reg;
            end
            state_reg <= fcs_pkg::E_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        fcs_pkg::E_HOLD: begin
          // Data stays driven past the write strobe rise
          fl_ce_n <= 1'b1;
          fl_dq_oe <= 1'b0;
          done_reg <= 1'b1;
          cnt_reg <= 4'(fcs_pkg::REC_CYC - 1);
          state_reg <= fcs_pkg::E_GAP;
        end
        fcs_pkg::E_GAP: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= fcs_pkg::E_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= fcs_pkg::E_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** bench/fcs_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
  parameter logic [15:0] ID_CODE = 16'h5a3c, // Arbitrary value
  parameter logic [6:0] PROT_SECT = 7'h05
) (
  // Bus from controller
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [18:0] addr,
  input wire logic [15:0] dq_o,
  // Fault control
  input wire logic stuck,
  // Device outputs
  output logic [15:0] dq_i,
  output logic rb_low
);
  logic [18:0] wa, pa;
  logic [15:0] pv, rd_val;
  logic [1:0] stage;
  logic busy, arm, id_mode, tog, byp;
  int left;
  initial begin
    {stage, busy, arm, id_mode, tog, byp} = '0;
    {pa, pv, rd_val, left} = {19'h0, 16'hffff, 16'h0, 32'h0};
  end
  // Released bus shows the inverse so a stale word cannot pass
  assign dq_i = (!ce_n && !oe_n) ? rd_val : ~rd_val;
  assign rb_low = busy;
  always @(negedge we_n) if (!ce_n) wa = addr;
  always @(posedge we_n) if (!ce_n) begin
    if (arm)
      {arm, pa, pv, busy, left} = {1'b0, wa, dq_o, 1'b1, 32'h3};
    else if (byp && dq_o[7:0] == 8'ha0)
      arm = 1'b1;
    else if (byp && dq_o[7:0] == 8'h90)
      stage = 2'h3;
    else if (stage == 3 && dq_o[7:0] == 8'h00)
      {byp, stage} = 3'b000;
    else if (dq_o[7:0] == 8'hf0)
      {busy, id_mode, stage} = '0;
    else if (stage == 0 && wa[11:0] == 12'h555 && dq_o[7:0] == 8'haa)
      stage = 2'h1;
    else if (stage == 1 && wa[11:0] == 12'h2aa && dq_o[7:0] == 8'h55)
      stage = 2'h2;
    else if (stage == 2 && dq_o[7:0] == 8'ha0)
      {arm, stage} = 3'b100;
    else if (stage == 2 && dq_o[7:0] == 8'h90)
      {id_mode, stage} = 3'b100;
    else if (stage == 2 && dq_o[7:0] == 8'h20)
      {byp, stage} = 3'b100;
    else
      stage = 2'h0;
  end
  always @(negedge oe_n) if (!ce_n) begin
    if (busy) begin
      tog = ~tog;
      rd_val = {8'h00, ~pv[7], tog, stuck, 5'h00};
      if (!stuck)
        left = left - 1;
      if (left == 0)
        busy = 1'b0;
    end else if (id_mode)
      rd_val = (addr[11:0] != 12'h002) ? ID_CODE :
        {15'h0, addr[18:12] == PROT_SECT};
    else
      rd_val = (addr == pa) ? pv : 16'hffff;
  end
endmodule
`default_nettype wire

// *** bench/fcs_flash_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_ctrl_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Flash pins
  input wire logic [18:0] FL_ADDR,
  input wire logic [15:0] FL_DQ_OUT,
  input wire logic FL_DQ_OE,
  input wire logic FL_CE_N,
  input wire logic FL_WE_N,
  input wire logic FL_OE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_we_in_ce: assert property (!FL_WE_N |-> !FL_CE_N)
    else $error("write strobe outside chip select");
  a_oe_in_ce: assert property (!FL_OE_N |-> !FL_CE_N)
    else $error("output enable outside chip select");
  a_we_oe_excl: assert property (!(!FL_WE_N && !FL_OE_N))
    else $error("write and read strobes together");
  a_write_drives: assert property (!FL_WE_N |-> FL_DQ_OE)
    else $error("data not driven in write");
  a_read_floats: assert property (!FL_OE_N |-> !FL_DQ_OE)
    else $error("data driven during read");
  a_we_width: assert property ($fell(FL_WE_N) |-> !FL_WE_N[*4] ##1 FL_WE_N)
    else $error("write pulse width wrong");
  a_wr_hold: assert property (
    !FL_WE_N |-> $stable(FL_ADDR) && $stable(FL_DQ_OUT))
    else $error("address or data moved in write pulse");
  a_ce_close: assert property ($rose(FL_WE_N) |-> ##[1:2] FL_CE_N)
    else $error("chip select not released");
  a_oe_width: assert property (
    $fell(FL_OE_N) |-> !FL_OE_N[*8] ##[1:2] FL_OE_N)
    else $error("read pulse width wrong");
  a_rdata_quiet: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside its cycle");
  c_write: cover property ($fell(FL_WE_N));
  c_read: cover property ($fell(FL_OE_N));
  c_done: cover property ($past(REG_RD) && REG_RDATA[1]);
endmodule
bind fcs_flash_ctrl fcs_flash_ctrl_chk u_chk (.CLK(CLK), .RST(RST),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FL_ADDR(FL_ADDR),
  .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N),
  .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N));
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] ID = 16'h5a3c;
  logic clk, rst, reg_wr, reg_rd, stuck, dq_oe, ce_n, we_n, oe_n, rb_low;
  logic saw_busy;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, s;
  logic [18:0] fl_addr;
  logic [15:0] dq_out, dq_dev, dq_in;
  wire logic rb_n;
  int fail_count, n_checks, cyc;
  // Pin levels from all drivers; ready line is the inverse of the model's busy flag
  assign dq_in = dq_oe ? dq_out : dq_dev;
  assign rb_n = !rb_low;
  fcs_flash_ctrl u_dut (.CLK(clk), .RST(rst), .CLK_EN(1'b1),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FL_ADDR(fl_addr),
    .FL_DQ_OUT(dq_out), .FL_DQ_OE(dq_oe), .FL_DQ_IN(dq_in),
    .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n),
    .FL_READY_BUSY_N(rb_n));
  fcs_flash_model #(.ID_CODE(ID), .PROT_SECT(7'h05)) u_flash (.ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .addr(fl_addr), .dq_o(dq_out),
    .stuck(stuck), .dq_i(dq_dev), .rb_low(rb_low));
  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Polling is bounded; a stuck busy ends the loop after 400 status reads
  task automatic op(input logic [3:0] code);
    wr(fcs_pkg::OFF_CTRL, {28'h0, code});
    repeat (2) @(posedge clk);
    saw_busy = 1'b0;
    for (int i = 0; i < 400; i++) begin
      rd(fcs_pkg::OFF_STATUS, s);
      if (s[fcs_pkg::ST_READY_PIN] === 1'b0)
        saw_busy = 1'b1;
      if (s[fcs_pkg::ST_BUSY] === 1'b0)
        break;
    end
  endtask
  task automatic t_idle;
    rd(fcs_pkg::OFF_STATUS, s);
    chk("reset status", 32'h8, s);
    wr(fcs_pkg::OFF_CTRL, 32'hc);
    repeat (4) @(posedge clk);
    rd(fcs_pkg::OFF_STATUS, s);
    chk("bad op status", 32'h8, s);
    rd(8'h14, s);
    chk("unmapped", 32'h0, s);
  endtask
  task automatic t_program;
    wr(fcs_pkg::OFF_ADDR, 32'h3a5c6);
    wr(fcs_pkg::OFF_WDATA, 32'h5aa5);
    op(fcs_pkg::OP_PROG);
    chk("prog status", 32'ha, s);
    chk("busy pin", 32'h1, {31'h0, saw_busy});
    chk("prog addr", 32'h3a5c6, {13'h0, u_flash.pa});
    chk("prog data", 32'h5aa5, {16'h0, u_flash.pv});
    rd(fcs_pkg::OFF_RDATA, s);
    chk("final read", 32'h5aa5, s);
    wr(fcs_pkg::OFF_STATUS, 32'h2);
    rd(fcs_pkg::OFF_STATUS, s);
    chk("done clear", 32'h8, s);
    op(fcs_pkg::OP_READ);
    rd(fcs_pkg::OFF_RDATA, s);
    chk("array read", 32'h5aa5, s);
    wr(fcs_pkg::OFF_STATUS, 32'h2);
  endtask
  task automatic t_bypass;
    wr(fcs_pkg::OFF_WDATA, 32'h1234);
    op(fcs_pkg::OP_BYP_ENTER);
    chk("bypass on", 32'h1, {31'h0, u_flash.byp});
    op(fcs_pkg::OP_BYP_PROG);
    chk("bypass status", 32'ha, s);
    chk("bypass prog", 32'h1234, {16'h0, u_flash.pv});
    op(fcs_pkg::OP_BYP_RESET);
    chk("bypass off", 32'h0, {31'h0, u_flash.byp});
    wr(fcs_pkg::OFF_STATUS, 32'h2);
  endtask
  task automatic t_protect;
    for (int k = 0; k < 2; k++) begin
      wr(fcs_pkg::OFF_ADDR, {13'h0, k ? 7'h05 : 7'h03, 12'h000});
      op(fcs_pkg::OP_PROT_VERIFY);
      rd(fcs_pkg::OFF_RDATA, s);
      chk("protect", k, s);
      wr(fcs_pkg::OFF_STATUS, 32'h2);
    end
  endtask
  task automatic t_ident;
    wr(fcs_pkg::OFF_ADDR, 32'h0);
    op(fcs_pkg::OP_ID_READ);
    rd(fcs_pkg::OFF_RDATA, s);
    chk("ident", {16'h0, ID}, s);
    chk("ident exit", 32'h0, {31'h0, u_flash.id_mode});
    wr(fcs_pkg::OFF_STATUS, 32'h2);
  endtask
  task automatic t_fail;
    @(posedge clk);
    stuck <= 1'b1;
    op(fcs_pkg::OP_PROG);
    chk("fail status", 32'he, s);
    chk("fail reset", 32'h0, {31'h0, u_flash.busy});
    stuck <= 1'b0;
    wr(fcs_pkg::OFF_STATUS, 32'h6);
    rd(fcs_pkg::OFF_STATUS, s);
    chk("fail clear", 32'h8, s);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      finish_test;
    end
  end
  initial begin
    {rst, reg_wr, reg_rd, stuck} = 4'b1000;
    {reg_addr, reg_wdata} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_idle;
    t_program;
    t_protect;
    t_ident;
    t_bypass;
    t_fail;
    finish_test;
  end
endmodule
`default_nettype wire
